// >>> dei_pkg.sv
// Shared constants for the bridge error-flag and interrupt logic and its host
package dei_pkg;
  // ==========================================================
  // Device register offsets
  localparam logic [7:0] OFF_SOFT_RESET = 8'h09;
  localparam logic [7:0] OFF_PLL_EN = 8'h0D;
  localparam logic [7:0] OFF_IRQ_EN = 8'hE0;
  localparam logic [7:0] OFF_CHA_EN = 8'hE1;
  localparam logic [7:0] OFF_CHB_EN = 8'hE2;
  localparam logic [7:0] OFF_FLAGS_A = 8'hE5;
  localparam logic [7:0] OFF_FLAGS_B = 8'hE6;
  // ==========================================================
  // Field positions and masks
  localparam int BIT_LOCK_LOSS = 0;
  localparam int BIT_CTL = 0;
  localparam int ERR_LSB = 2;
  localparam int ERR_MSB = 7;
  localparam int ERR_PROTOCOL = 1;
  localparam logic [7:0] MASK_A = 8'hFD;
  localparam logic [7:0] MASK_B = 8'hFC;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FLAGS_A = 8'h01;
  localparam logic [7:0] RST_FLAGS_B = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ==========================================================
  // Host controller local offsets and control bits
  localparam logic [7:0] HOFF_CTRL = 8'h00;
  localparam logic [7:0] HOFF_STATUS = 8'h01;
  localparam logic [7:0] HOFF_RADDR = 8'h02;
  localparam logic [7:0] HOFF_RWDATA = 8'h03;
  localparam logic [7:0] HOFF_RREAD = 8'h04;
  localparam logic [7:0] HOFF_RRDATA = 8'h05;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CFG_DONE = 2;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int PLL_SETTLE_MS = 3;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_MS * (CLK_HZ / 1000));
  // ==========================================================
  // Host sequencer states
  typedef enum logic [3:0] {
    HS_IDLE, HS_RWRITE, HS_RREAD, HS_RWAIT,
    HS_STOP_PLL, HS_STOP_STREAM, HS_STOP_LANES,
    HS_CLR_A, HS_CLR_B, HS_START_STREAM, HS_START_PLL, HS_SETTLE, HS_SOFT_RESET
  } dei_host_state_e;
endpackage

// >>> dei_if.sv
// Link between the bridge error logic and its host: register port, interrupt pin, video state
interface dei_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq_out;
  logic irq_oe;
  logic irq_line;
  logic stream_active;
  logic lanes_lp11;

  // ==========================================================
  // Pin level: undriven interrupt pin is pulled low on the board
  assign irq_line = irq_oe & irq_out;

  modport dev (
    input reg_addr, input reg_wdata, input reg_wr, input reg_rd,
    output reg_rdata, output irq_out, output irq_oe,
    input stream_active, input lanes_lp11
  );
  modport host (
    output reg_addr, output reg_wdata, output reg_wr, output reg_rd,
    input reg_rdata, input irq_line,
    output stream_active, output lanes_lp11
  );
endinterface

// >>> dei_w1c_flags.sv
// Sticky write-one-to-clear flag register with set priority
module dei_w1c_flags #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] VALID = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] set,
  input wire logic clear_wr,
  input wire logic [WIDTH-1:0] clear_data,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] clear_bits;
  logic [WIDTH-1:0] next_flags;

  // Only a written one clears; a zero leaves the flag alone
  assign clear_bits = clear_wr ? clear_data : '0;
  // Set wins over a clear in the same cycle, so no event is lost
  assign next_flags = ((flags & ~clear_bits) | set) & VALID;

  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= RESET_VALUE & VALID;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// >>> dei_device.sv
// Device end: error flags, interrupt enables, PLL enable and soft reset of the bridge
// Summary of operation
// - PLL lock loss sets flag A bit 0
// - Channel B sync error sets bit 7
// - Channel B checksum error sets bit 6
// - Channel B uncorrectable header error sets bit 5
// - Channel B corrected header error sets bit 4
// - Channel B protocol error sets bit 3
// - Lane merge faults reported as protocol error
// - Channel B leader bit error sets bit 2
// - Flags clear only by writing one
// - Interrupt needs flag, its enable, global enable
// - Channel A enables in bits 7..2, lock loss enable in bit 0
// - Channel B enables in bits 7..2
// - Host stops: PLL off, stream off, LP11
// - Host restarts: stream, PLL, wait 3 ms, reset
// - Soft reset during stream may set flags
// - Host clears flags before restarting video
// - Host streams only after full configuration
// - Global enable low leaves interrupt undriven
// - Channel A flags in bits 7..2, same order
//
// The implementer's own choice: the plain strobed port.
module dei_device #(
  parameter int ERR_W = 6
) (
  input wire logic clk,
  input wire logic reset,
  dei_if.dev link,
  input wire logic pll_locked,
  input wire logic [ERR_W-1:0] chan_a_err_events,
  input wire logic chan_a_lane_merge_fault,
  input wire logic chan_b_sync_fault,
  input wire logic chan_b_checksum_fault,
  input wire logic chan_b_header_uncorrectable,
  input wire logic chan_b_header_corrected,
  input wire logic chan_b_protocol_fault,
  input wire logic chan_b_lane_merge_fault,
  input wire logic chan_b_leader_bit_fault,
  output logic pll_enable,
  output logic soft_reset_pulse,
  output logic video_idle
);
  // ==========================================================
  // Register state
  logic irq_enable;
  logic [7:0] chan_a_enable;
  logic [7:0] chan_b_enable;
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] rdata;

  // ==========================================================
  // Lock status synchroniser and edge detect
  logic lock_meta;
  logic lock_sync;
  logic lock_prev;
  logic lock_lost;

  always_ff @(posedge clk) begin
    if (reset) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      lock_meta <= pll_locked;
      lock_sync <= lock_meta;
      lock_prev <= lock_sync;
    end
  end

  // Only a locked-to-unlocked step counts, not a PLL that never locked
  assign lock_lost = lock_prev & ~lock_sync;

  // ==========================================================
  // Address decode
  logic hit_soft_reset;
  logic hit_pll_en;
  logic hit_irq_en;
  logic hit_cha_en;
  logic hit_chb_en;
  logic hit_flags_a;
  logic hit_flags_b;
  logic wr_soft_reset;
  logic wr_pll_en;
  logic wr_irq_en;
  logic wr_cha_en;
  logic wr_chb_en;
  logic wr_flags_a;
  logic wr_flags_b;

  assign hit_soft_reset = (link.reg_addr == dei_pkg::OFF_SOFT_RESET);
  assign hit_pll_en = (link.reg_addr == dei_pkg::OFF_PLL_EN);
  assign hit_irq_en = (link.reg_addr == dei_pkg::OFF_IRQ_EN);
  assign hit_cha_en = (link.reg_addr == dei_pkg::OFF_CHA_EN);
  assign hit_chb_en = (link.reg_addr == dei_pkg::OFF_CHB_EN);
  assign hit_flags_a = (link.reg_addr == dei_pkg::OFF_FLAGS_A);
  assign hit_flags_b = (link.reg_addr == dei_pkg::OFF_FLAGS_B);
  assign wr_soft_reset = link.reg_wr & hit_soft_reset;
  assign wr_pll_en = link.reg_wr & hit_pll_en;
  assign wr_irq_en = link.reg_wr & hit_irq_en;
  assign wr_cha_en = link.reg_wr & hit_cha_en;
  assign wr_chb_en = link.reg_wr & hit_chb_en;
  assign wr_flags_a = link.reg_wr & hit_flags_a;
  assign wr_flags_b = link.reg_wr & hit_flags_b;

  // ==========================================================
  // Soft reset side effect on an active stream
  logic reset_cuts_stream;
  logic soft_reset_req;

  assign soft_reset_req = wr_soft_reset & link.reg_wdata[dei_pkg::BIT_CTL];
  // A reset mid-packet breaks lane framing on both channels
  assign reset_cuts_stream = soft_reset_req & link.stream_active;

  // ==========================================================
  // Flag set vectors
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [ERR_W-1:0] events_a;
  logic [ERR_W-1:0] events_b;

  always_comb begin
    events_a = chan_a_err_events;
    events_a[dei_pkg::ERR_PROTOCOL] = chan_a_err_events[dei_pkg::ERR_PROTOCOL]
      | chan_a_lane_merge_fault | reset_cuts_stream;
  end

  assign events_b = {
    chan_b_sync_fault,
    chan_b_checksum_fault,
    chan_b_header_uncorrectable,
    chan_b_header_corrected,
    chan_b_protocol_fault | chan_b_lane_merge_fault | reset_cuts_stream,
    chan_b_leader_bit_fault
  };

  assign set_a = {events_a, 1'b0, lock_lost};
  assign set_b = {events_b, 2'b00};

  // ==========================================================
  // Sticky flag registers
  dei_w1c_flags #(
    .WIDTH(8),
    .RESET_VALUE(dei_pkg::RST_FLAGS_A),
    .VALID(dei_pkg::MASK_A)
  ) u_flags_a (
    .clk(clk),
    .reset(reset),
    .set(set_a),
    .clear_wr(wr_flags_a),
    .clear_data(link.reg_wdata),
    .flags(flags_a)
  );

  dei_w1c_flags #(
    .WIDTH(8),
    .RESET_VALUE(dei_pkg::RST_FLAGS_B),
    .VALID(dei_pkg::MASK_B)
  ) u_flags_b (
    .clk(clk),
    .reset(reset),
    .set(set_b),
    .clear_wr(wr_flags_b),
    .clear_data(link.reg_wdata),
    .flags(flags_b)
  );

  logic chan_b_sync_fault_flag;
  logic chan_b_checksum_fault_flag;
  logic chan_b_header_uncorrectable_flag;
  logic chan_b_header_corrected_flag;
  logic chan_b_protocol_fault_flag;
  logic chan_b_leader_bit_fault_flag;
  logic chan_a_sync_fault_flag;

  assign chan_b_sync_fault_flag = flags_b[7];
  assign chan_b_checksum_fault_flag = flags_b[6];
  assign chan_b_header_uncorrectable_flag = flags_b[5];
  assign chan_b_header_corrected_flag = flags_b[4];
  assign chan_b_protocol_fault_flag = flags_b[3];
  assign chan_b_leader_bit_fault_flag = flags_b[2];
  assign chan_a_sync_fault_flag = flags_a[7];

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_enable <= 1'b0;
      pll_enable <= 1'b0;
      chan_a_enable <= dei_pkg::RST_ZERO;
      chan_b_enable <= dei_pkg::RST_ZERO;
      soft_reset_pulse <= 1'b0;
    end else begin
      if (wr_irq_en) begin
        irq_enable <= link.reg_wdata[dei_pkg::BIT_CTL];
      end
      if (wr_pll_en) begin
        pll_enable <= link.reg_wdata[dei_pkg::BIT_CTL];
      end
      if (wr_cha_en) begin
        chan_a_enable <= link.reg_wdata & dei_pkg::MASK_A;
      end
      if (wr_chb_en) begin
        chan_b_enable <= link.reg_wdata & dei_pkg::MASK_B;
      end
      soft_reset_pulse <= soft_reset_req;
    end
  end

  // ==========================================================
  // Interrupt pin
  logic any_pending;

  assign any_pending = |(flags_a & chan_a_enable) | |(flags_b & chan_b_enable);
  // Pin only driven while globally enabled, else left to the pull
  assign link.irq_oe = irq_enable;
  assign link.irq_out = irq_enable & any_pending;

  // ==========================================================
  // Read port: data in the cycle after the strobe only
  logic [7:0] read_mux;

  assign read_mux =
    hit_pll_en ? {7'b0, pll_enable} :
    hit_irq_en ? {7'b0, irq_enable} :
    hit_cha_en ? chan_a_enable :
    hit_chb_en ? chan_b_enable :
    hit_flags_a ? flags_a :
    hit_flags_b ? flags_b :
    dei_pkg::RST_ZERO;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= dei_pkg::RST_ZERO;
      video_idle <= 1'b0;
    end else begin
      rdata <= link.reg_rd ? read_mux : dei_pkg::RST_ZERO;
      video_idle <= link.lanes_lp11 & ~link.stream_active;
    end
  end

  assign link.reg_rdata = rdata;
endmodule

// >>> dei_host.sv
// Host end: video stop/restart sequencer and register access toward the bridge
module dei_host #(
  parameter int SETTLE_CYCLES = dei_pkg::PLL_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  dei_if.host link,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq_pending
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  dei_pkg::dei_host_state_e state, next_state;
  logic [7:0] raddr;
  logic [7:0] rwdata;
  logic [7:0] rrdata;
  logic cfg_done;
  logic streaming;
  logic lp11;
  logic [CW-1:0] settle;
  logic irq_meta;
  logic rd_done;
  logic next_wr;
  logic next_rd;
  logic [7:0] next_addr;
  logic [7:0] next_wdata;
  logic idle;
  logic ctrl_wr;
  logic go_start;
  logic go_stop;

  // ==========================================================
  // Local command decode; orders while busy are dropped
  assign idle = (state == dei_pkg::HS_IDLE);
  assign ctrl_wr = sw_wr & (sw_addr == dei_pkg::HOFF_CTRL);
  // Start is refused until configuration is declared finished
  assign go_start = ctrl_wr & sw_wdata[dei_pkg::CTRL_START] & cfg_done;
  assign go_stop = ctrl_wr & sw_wdata[dei_pkg::CTRL_STOP];

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_addr = link.reg_addr;
    next_wdata = link.reg_wdata;
    case (state)
      dei_pkg::HS_IDLE: begin
        if (go_stop) begin
          next_state = dei_pkg::HS_STOP_PLL;
        end else if (go_start) begin
          next_state = dei_pkg::HS_CLR_A;
        end else if (sw_wr && sw_addr == dei_pkg::HOFF_RWDATA) begin
          next_state = dei_pkg::HS_RWRITE;
        end else if (sw_wr && sw_addr == dei_pkg::HOFF_RREAD) begin
          next_state = dei_pkg::HS_RREAD;
        end
      end
      dei_pkg::HS_RWRITE: begin
        {next_wr, next_addr, next_wdata} = {1'b1, raddr, rwdata};
        next_state = dei_pkg::HS_IDLE;
      end
      dei_pkg::HS_RREAD: begin
        {next_rd, next_addr} = {1'b1, raddr};
        next_state = dei_pkg::HS_RWAIT;
      end
      dei_pkg::HS_RWAIT: next_state = dei_pkg::HS_IDLE;
      dei_pkg::HS_STOP_PLL: begin
        {next_wr, next_addr, next_wdata} = {1'b1, dei_pkg::OFF_PLL_EN, dei_pkg::RST_ZERO};
        next_state = dei_pkg::HS_STOP_STREAM;
      end
      dei_pkg::HS_STOP_STREAM: next_state = dei_pkg::HS_STOP_LANES;
      dei_pkg::HS_STOP_LANES: next_state = dei_pkg::HS_IDLE;
      dei_pkg::HS_CLR_A: begin
        {next_wr, next_addr, next_wdata} = {1'b1, dei_pkg::OFF_FLAGS_A, dei_pkg::ALL_ONES};
        next_state = dei_pkg::HS_CLR_B;
      end
      dei_pkg::HS_CLR_B: begin
        {next_wr, next_addr, next_wdata} = {1'b1, dei_pkg::OFF_FLAGS_B, dei_pkg::ALL_ONES};
        next_state = dei_pkg::HS_START_STREAM;
      end
      dei_pkg::HS_START_STREAM: next_state = dei_pkg::HS_START_PLL;
      dei_pkg::HS_START_PLL: begin
        {next_wr, next_addr, next_wdata} = {1'b1, dei_pkg::OFF_PLL_EN, 8'h01};
        next_state = dei_pkg::HS_SETTLE;
      end
      dei_pkg::HS_SETTLE: begin
        if (settle == CW'(SETTLE_CYCLES)) begin
          next_state = dei_pkg::HS_SOFT_RESET;
        end
      end
      dei_pkg::HS_SOFT_RESET: begin
        {next_wr, next_addr, next_wdata} = {1'b1, dei_pkg::OFF_SOFT_RESET, 8'h01};
        next_state = dei_pkg::HS_IDLE;
      end
      default: next_state = dei_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= dei_pkg::HS_IDLE;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= dei_pkg::RST_ZERO;
      link.reg_wdata <= dei_pkg::RST_ZERO;
    end else begin
      state <= next_state;
      link.reg_wr <= next_wr;
      link.reg_rd <= next_rd;
      link.reg_addr <= next_addr;
      link.reg_wdata <= next_wdata;
    end
  end

  // ==========================================================
  // Stream and lane state, settle timer
  always_ff @(posedge clk) begin
    if (reset) begin
      streaming <= 1'b0;
      lp11 <= 1'b1;
      settle <= '0;
    end else begin
      if (state == dei_pkg::HS_STOP_STREAM) begin
        streaming <= 1'b0;
      end
      if (state == dei_pkg::HS_STOP_LANES) begin
        lp11 <= 1'b1;
      end
      if (state == dei_pkg::HS_START_STREAM) begin
        streaming <= 1'b1;
        lp11 <= 1'b0;
      end
      // At least the settle time passes after the PLL enable write
      settle <= (state == dei_pkg::HS_SETTLE) ? settle + 1'b1 : '0;
    end
  end

  assign link.stream_active = streaming;
  assign link.lanes_lp11 = lp11;

  // ==========================================================
  // Local registers and read port
  always_ff @(posedge clk) begin
    if (reset) begin
      raddr <= dei_pkg::RST_ZERO;
      rwdata <= dei_pkg::RST_ZERO;
      rrdata <= dei_pkg::RST_ZERO;
      cfg_done <= 1'b0;
      irq_meta <= 1'b0;
      rd_done <= 1'b0;
      irq_pending <= 1'b0;
      sw_rdata <= dei_pkg::RST_ZERO;
    end else begin
      if (idle && sw_wr && sw_addr == dei_pkg::HOFF_RADDR) begin
        raddr <= sw_wdata;
      end
      if (idle && sw_wr && sw_addr == dei_pkg::HOFF_RWDATA) begin
        rwdata <= sw_wdata;
      end
      if (ctrl_wr) begin
        cfg_done <= sw_wdata[dei_pkg::CTRL_CFG_DONE];
      end
      // Read data stand only in the cycle after the strobe
      rd_done <= link.reg_rd;
      if (rd_done) begin
        rrdata <= link.reg_rdata;
      end
      irq_meta <= link.irq_line;
      irq_pending <= irq_meta;
      sw_rdata <= !sw_rd ? dei_pkg::RST_ZERO :
        (sw_addr == dei_pkg::HOFF_CTRL) ? {5'b0, cfg_done, 2'b00} :
        (sw_addr == dei_pkg::HOFF_STATUS) ? {4'b0, lp11, irq_pending, streaming, ~idle} :
        (sw_addr == dei_pkg::HOFF_RADDR) ? raddr :
        (sw_addr == dei_pkg::HOFF_RWDATA) ? rwdata :
        (sw_addr == dei_pkg::HOFF_RRDATA) ? rrdata :
        dei_pkg::RST_ZERO;
    end
  end
endmodule

// >>> dei_link_sva.sv
// Interface checks for the bridge error logic and its host
module dei_link_sva #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic irq_line,
  input wire logic stream_active,
  input wire logic lanes_lp11
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Decoded accesses
  wire wr_pll = reg_wr && (reg_addr == dei_pkg::OFF_PLL_EN);
  wire wr_pll_on = wr_pll && reg_wdata[0];
  wire wr_soft = reg_wr && (reg_addr == dei_pkg::OFF_SOFT_RESET);
  wire wr_irq_en = reg_wr && (reg_addr == dei_pkg::OFF_IRQ_EN);
  wire clr_b_all = reg_wr && (reg_addr == dei_pkg::OFF_FLAGS_B) && (reg_wdata == 8'hFF);
  wire rd_a = reg_rd && (reg_addr == dei_pkg::OFF_FLAGS_A);
  wire rd_a_en = reg_rd && (reg_addr == dei_pkg::OFF_CHA_EN);
  wire rd_b = reg_rd && (reg_addr == dei_pkg::OFF_FLAGS_B || reg_addr == dei_pkg::OFF_CHB_EN);
  int settle_cnt;
  // Saturating, so a long idle spell never wraps round
  always_ff @(posedge clk) begin
    if (reset || wr_pll_on) begin
      settle_cnt <= 0;
    end else if (settle_cnt < SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 1;
    end
  end
  // ==========================================================
  // Properties
  property p_irq_gated;
    irq_out |-> irq_oe;
  endproperty
  property p_oe_follows;
    wr_irq_en |=> irq_oe == $past(reg_wdata[0]);
  endproperty
  property p_a_reserved;
    rd_a |=> reg_rdata[1] == 1'b0;
  endproperty
  property p_a_en_reserved;
    rd_a_en |=> reg_rdata[1] == 1'b0;
  endproperty
  property p_b_reserved;
    rd_b |=> reg_rdata[1:0] == 2'h0;
  endproperty
  property p_stop_order;
    wr_pll && !reg_wdata[0] && stream_active |=> !stream_active ##1 lanes_lp11;
  endproperty
  property p_pll_after_stream;
    $rose(stream_active) |-> !lanes_lp11 ##1 wr_pll_on;
  endproperty
  property p_settle;
    wr_soft |-> settle_cnt >= SETTLE_CYCLES;
  endproperty
  property p_clear_first;
    $rose(stream_active) |-> $past(clr_b_all);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("interrupt raised while undriven");
  a_oe_follows: assert property (p_oe_follows) else $error("pin enable not as written");
  a_a_reserved: assert property (p_a_reserved) else $error("flags a bit1 not zero");
  a_a_en_reserved: assert property (p_a_en_reserved) else $error("enable a bit1 not zero");
  a_b_reserved: assert property (p_b_reserved) else $error("channel b bits 1:0 not zero");
  a_stop_order: assert property (p_stop_order) else $error("stop order broken");
  a_pll_after_stream: assert property (p_pll_after_stream) else $error("pll not enabled");
  a_settle: assert property (p_settle) else $error("soft reset before settle time");
  a_clear_first: assert property (p_clear_first) else $error("stream began uncleared");
  c_stop: cover property (wr_pll && !reg_wdata[0] && stream_active);
  c_start: cover property ($rose(stream_active));
  c_irq: cover property (irq_line);
endmodule

// >>> dsi_error_irq_status_tb.sv
// Testbench joining the bridge error logic and its host
`define CHK(name, want_v, got_v) \
  begin \
    n_compared++; \
    if ((got_v) !== (want_v)) begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %h seen %h", name, want_v, got_v); \
    end \
  end
module dsi_error_irq_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  localparam int LIMIT = 30000;
  logic clk;
  logic reset;
  logic pll_locked;
  logic [5:0] a_ev;
  logic a_merge;
  logic [6:0] b_ev;
  logic [7:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_rdata;
  logic irq_pending;
  logic pll_enable;
  logic soft_reset_pulse;
  logic video_idle;
  logic [7:0] rd;
  logic [31:0] r;
  int n_errors;
  int n_compared;
  int cycles;
  int n_soft;
  int seed;
  int k;
  dei_if link();
  dei_device u_dei_device (.clk(clk), .reset(reset), .link(link), .pll_locked(pll_locked),
    .chan_a_err_events(a_ev), .chan_a_lane_merge_fault(a_merge),
    .chan_b_sync_fault(b_ev[5]), .chan_b_checksum_fault(b_ev[4]),
    .chan_b_header_uncorrectable(b_ev[3]), .chan_b_header_corrected(b_ev[2]),
    .chan_b_protocol_fault(b_ev[1]), .chan_b_lane_merge_fault(b_ev[6]),
    .chan_b_leader_bit_fault(b_ev[0]), .pll_enable(pll_enable),
    .soft_reset_pulse(soft_reset_pulse), .video_idle(video_idle));
  dei_host #(.SETTLE_CYCLES(SETTLE)) u_dei_host (.clk(clk), .reset(reset), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq_pending(irq_pending));
  dei_link_sva #(.SETTLE_CYCLES(SETTLE)) u_dei_link_sva (.clk(clk), .reset(reset),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .irq_out(link.irq_out),
    .irq_oe(link.irq_oe), .irq_line(link.irq_line), .stream_active(link.stream_active),
    .lanes_lp11(link.lanes_lp11));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Watchdog and pulse counting
  always @(posedge clk) begin
    cycles++;
    if (soft_reset_pulse === 1'b1) begin
      n_soft++;
    end
    if (cycles >= LIMIT) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Software port and remote register access
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 && n < 100) begin
      sw_read(dei_pkg::HOFF_STATUS, s);
      n++;
    end
    `CHK("host idle", 1'b0, s[0])
  endtask
  task automatic dev_write(input logic [7:0] a, input logic [7:0] d);
    sw_write(dei_pkg::HOFF_RADDR, a);
    sw_write(dei_pkg::HOFF_RWDATA, d);
    wait_idle();
  endtask
  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [7:0] w);
    logic [7:0] d;
    sw_write(dei_pkg::HOFF_RADDR, a);
    sw_write(dei_pkg::HOFF_RREAD, 8'h00);
    wait_idle();
    sw_read(dei_pkg::HOFF_RRDATA, d);
    `CHK(nm, w, d)
  endtask
  task automatic pulse_b(input int i);
    @(posedge clk);
    b_ev[i] <= 1'b1;
    @(posedge clk);
    b_ev[i] <= 1'b0;
  endtask
  // Lane merge (index 6) shares the protocol flag
  function automatic logic [7:0] b_bit(input int i);
    return (i == 6) ? 8'h08 : 8'(1 << (i + 2));
  endfunction
  task automatic check_irq(input logic ge, input logic [7:0] en, input logic [7:0] fl);
    repeat (4) @(posedge clk);
    #1;
    `CHK("irq pending", ge & (|(en & fl)), irq_pending)
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hd0e9;
    {n_errors, n_compared, cycles, n_soft} = '0;
    {reset, pll_locked, a_ev, a_merge, b_ev} = {1'b1, 15'h0000};
    {sw_addr, sw_wdata, sw_wr, sw_rd} = 18'h0_0000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    expect_reg("flags a reset", dei_pkg::OFF_FLAGS_A, 8'h01);
    expect_reg("flags b reset", dei_pkg::OFF_FLAGS_B, 8'h00);
    dev_write(8'h50, 8'hFF);
    expect_reg("unmapped", 8'h50, 8'h00);
    dev_write(dei_pkg::OFF_CHA_EN, 8'hFF);
    expect_reg("chan a enables", dei_pkg::OFF_CHA_EN, 8'hFD);
    dev_write(dei_pkg::OFF_FLAGS_A, 8'h00);
    expect_reg("lock flag kept", dei_pkg::OFF_FLAGS_A, 8'h01);
    dev_write(dei_pkg::OFF_FLAGS_A, 8'h01);
    expect_reg("lock flag cleared", dei_pkg::OFF_FLAGS_A, 8'h00);
    @(posedge clk);
    pll_locked <= 1'b1;
    repeat (10) @(posedge clk);
    pll_locked <= 1'b0;
    repeat (10) @(posedge clk);
    expect_reg("lock loss", dei_pkg::OFF_FLAGS_A, 8'h01);
    dev_write(dei_pkg::OFF_FLAGS_A, 8'h01);
    for (int i = 0; i < 7; i++) begin
      pulse_b(i);
      expect_reg("b flag set", dei_pkg::OFF_FLAGS_B, b_bit(i));
      dev_write(dei_pkg::OFF_FLAGS_B, ~b_bit(i));
      expect_reg("b flag kept", dei_pkg::OFF_FLAGS_B, b_bit(i));
      dev_write(dei_pkg::OFF_FLAGS_B, b_bit(i));
      expect_reg("b flag cleared", dei_pkg::OFF_FLAGS_B, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      @(posedge clk);
      a_ev <= r[5:0];
      a_merge <= (i == 0);
      @(posedge clk);
      {a_ev, a_merge} <= 7'h00;
      expect_reg("a flags", dei_pkg::OFF_FLAGS_A, {r[5:0] | 6'(i == 0 ? 2 : 0), 2'h0});
      dev_write(dei_pkg::OFF_FLAGS_A, 8'hFF);
    end
    // First pass is the fully enabled corner
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 32'h0000_11FD : $random(seed);
      k = $unsigned(r[11:9]) % 7;
      dev_write(dei_pkg::OFF_CHB_EN, r[7:0]);
      dev_write(dei_pkg::OFF_CHA_EN, r[7:0]);
      dev_write(dei_pkg::OFF_IRQ_EN, {7'h00, r[8]});
      pulse_b(k);
      check_irq(r[8], r[7:0] & dei_pkg::MASK_B, b_bit(k));
      dev_write(dei_pkg::OFF_FLAGS_B, 8'hFF);
      @(posedge clk);
      a_ev <= 6'(1 << r[14:12] % 6);
      @(posedge clk);
      a_ev <= 6'h00;
      check_irq(r[8], r[7:0] & dei_pkg::MASK_A, 8'(1 << (r[14:12] % 6 + 2)));
      dev_write(dei_pkg::OFF_FLAGS_A, 8'hFF);
    end
    dev_write(dei_pkg::OFF_IRQ_EN, 8'h00);
    check_irq(1'b0, 8'hFF, 8'hFF);
    sw_write(dei_pkg::HOFF_CTRL, 8'h01);
    wait_idle();
    sw_read(dei_pkg::HOFF_STATUS, rd);
    `CHK("start refused", 4'h8, rd[3:0])
    sw_write(dei_pkg::HOFF_CTRL, 8'h04);
    sw_write(dei_pkg::HOFF_CTRL, 8'h05);
    wait_idle();
    sw_read(dei_pkg::HOFF_STATUS, rd);
    `CHK("streaming", 4'h2, rd[3:0])
    `CHK("pll on", 1'b1, pll_enable)
    `CHK("one soft reset", 1, n_soft)
    expect_reg("soft reset flags a", dei_pkg::OFF_FLAGS_A, 8'h08);
    expect_reg("soft reset flags b", dei_pkg::OFF_FLAGS_B, 8'h08);
    sw_write(dei_pkg::HOFF_CTRL, 8'h02);
    wait_idle();
    sw_read(dei_pkg::HOFF_STATUS, rd);
    `CHK("stopped", 4'h8, rd[3:0])
    `CHK("pll off", 1'b0, pll_enable)
    `CHK("video idle", 1'b1, video_idle)
    conclude();
  end
endmodule
